/* design/rps_consts.vh */
// Constants for the rotor position sampler: register map, fields, timing
// How it works
// RULE1 - Enable bit starts sampling, zero holds idle
// RULE2 - Mode bit picks ordinary or unmatch detection
// RULE3 - Option bit restarts match count per on-interval
// RULE4 - Pin-count bit compares three pins or one
// RULE5 - Second timer event starts sampling when enabled
// RULE6 - Third timer event stops sampling when enabled
// RULE7 - Writing one to start bit starts sampling
// RULE8 - Writing one to stop bit stops sampling
// RULE9 - Four-bit field sets required matches 1 to 15
// RULE10 - Sampling mode gates by PWM or lower phases
// RULE11 - Sampling clock is system clock over 4..32
// RULE12 - Unmatch mode holds sampled W V U levels
// RULE13 - Status bit shows sampling in progress
// RULE14 - Two-bit field reports where detection occurred
// RULE15 - Delay field postpones sampling in eight-clock steps
// RULE16 - Software sets pin latches to one first
// RULE17 - Each motor pin direction set individually
// RULE18 - Port B low bits carry position inputs
// RULE19 - Mismatch clears counter; detect at programmed count
// RULE20 - Inputs pass two flip-flops; all logic synchronous (only port B inputs here; port A pins feed the read mux directly)
`ifndef RPS_CONSTS_VH
`define RPS_CONSTS_VH
`define RPS_IDX_PORT_A_DATA   16'h0003
`define RPS_IDX_PORT_B_DATA   16'h0004
`define RPS_IDX_PORT_A_DIR    16'h1f89
`define RPS_IDX_PORT_B_DIR    16'h1f8a
`define RPS_IDX_CTRL_A        16'h1fa0
`define RPS_IDX_CTRL_B        16'h1fa1
`define RPS_IDX_STATUS        16'h1fa2
`define RPS_IDX_DELAY         16'h1fa3
`define RPS_CA_ENABLE         0
`define RPS_CA_UNMATCH        1
`define RPS_CA_RECOUNT        2
`define RPS_CA_ONEPIN         3
`define RPS_CA_T2START        4
`define RPS_CA_T3STOP         5
`define RPS_CA_SWSTART        6
`define RPS_CA_SWSTOP         7
`define RPS_SMODE_PWMON       2'h0
`define RPS_SMODE_ALWAYS      2'h1
`define RPS_SMODE_LOWON       2'h2
`define RPS_LOC_CURRENT       2'h0
`define RPS_LOC_PWMOFF        2'h1
`define RPS_LOC_PRECEDING     2'h3
`define RPS_DELAY_STEP        4'h8
`define RPS_DIV_BASE          6'h04
`define RPS_RESET_BYTE        8'h00
`define RPS_LATCH_RESET       8'hff
`endif

/* design/rps_rotor_position_sampler.v */
// Rotor position sampler with APB register access and motor port pins
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "rps_consts.vh"
module rps_rotor_position_sampler #(
    parameter ABITS = 16
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset,
    // APB slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [ABITS-1:0] paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    // Motor port A pins
    input  wire [7:0]       portAIn,
    output reg  [7:0]       portAOut,
    output reg  [7:0]       portAOe,
    // Motor port B pins, low three are position inputs
    input  wire [2:0]       portBIn,
    output reg  [2:0]       portBOut,
    output reg  [2:0]       portBOe,
    // PWM state and timer events
    input  wire             pwmOn,
    input  wire             lowerPhaseOn,
    input  wire             timer2Event,
    input  wire             timer3Event,
    input  wire [2:0]       expectedPattern,
    // Detection result
    output reg              positionDetected
);
    reg  [7:0] latchA;
    reg  [2:0] latchB;
    reg  [7:0] dirA;
    reg  [2:0] dirB;
    reg  [5:0] ctrlA;
    reg  [7:0] ctrlB;
    reg  [6:0] delayVal;
    reg  [2:0] syncA;
    reg  [2:0] syncB;
    reg        sampling;
    reg  [2:0] heldLevels;
    reg  [1:0] location;
    reg  [3:0] matchCount;
    reg  [4:0] divCount;
    reg  [9:0] delayCount;
    reg        delayDone;
    reg        pwmOnPrev;
    reg        matchedInPulse;
    reg        pulseSeen;
    localparam       PINS_A     = 8;
    localparam       PINS_B     = 3;
    localparam [7:0] LATCH_INIT = `RPS_LATCH_RESET;
    localparam [7:0] DIR_INIT   = `RPS_RESET_BYTE;
    wire [15:0] index = {{(18-ABITS){1'b0}}, paddr[ABITS-1:2]};
    wire        wordOk = (paddr[1:0] == 2'h0);
    wire        wrEn = psel & penable & pwrite & pready;
    wire [7:0]  wb = pwdata[7:0];
    reg         mapped;
    reg  [7:0]  rdByte;

    always @* begin
        mapped = wordOk;
        rdByte = `RPS_RESET_BYTE;
        if (index == `RPS_IDX_PORT_A_DATA) begin
            rdByte = (dirA & latchA) | (~dirA & portAIn);
        end else if (index == `RPS_IDX_PORT_B_DATA) begin
            // RULE18 position inputs
            rdByte = {5'h00, (dirB & latchB) | (~dirB & syncB)};
        end else if (index == `RPS_IDX_PORT_A_DIR) begin
            rdByte = dirA;
        end else if (index == `RPS_IDX_PORT_B_DIR) begin
            rdByte = {5'h00, dirB};
        end else if (index == `RPS_IDX_CTRL_A) begin
            rdByte = {2'h0, ctrlA};
        end else if (index == `RPS_IDX_CTRL_B) begin
            rdByte = ctrlB;
        end else if (index == `RPS_IDX_STATUS) begin
            // RULE13 sampling status
            rdByte = {2'h0, location, sampling, heldLevels};
        end else if (index == `RPS_IDX_DELAY) begin
            rdByte = {1'b0, delayVal};
        end else begin
            mapped = 1'b0;
        end
    end

    // Bus slave: one wait state, error on unmapped or unaligned address
    always @(posedge clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel & penable & ~pready & ~pwrite) begin
                prdata <= mapped ? {24'h000000, rdByte} : 32'h00000000;
            end
        end
    end

    wire wrA    = wrEn & mapped & (index == `RPS_IDX_CTRL_A);
    wire swStart = wrA & wb[`RPS_CA_SWSTART];
    wire swStop  = wrA & wb[`RPS_CA_SWSTOP];
    wire enable  = ctrlA[`RPS_CA_ENABLE];
    // Enable as it stands after this edge, so the 0 to 1 write itself starts a run
    wire nextEnable = wrA ? wb[`RPS_CA_ENABLE] : enable;
    // RULE6 RULE8 stop sources
    wire stopReq  = swStop | (ctrlA[`RPS_CA_T3STOP] & timer3Event);
    // RULE1 RULE5 RULE7 start sources
    wire startReq = swStart | (ctrlA[`RPS_CA_T2START] & timer2Event) | (nextEnable & ~enable);

    // Register writes
    always @(posedge clk) begin
        if (reset) begin
            latchA   <= `RPS_LATCH_RESET;
            latchB   <= 3'h7;
            dirA     <= `RPS_RESET_BYTE;
            dirB     <= 3'h0;
            ctrlA    <= 6'h00;
            ctrlB    <= `RPS_RESET_BYTE;
            delayVal <= 7'h00;
        end else if (wrEn & mapped) begin
            if (index == `RPS_IDX_PORT_A_DATA) begin
                latchA <= wb;
            end else if (index == `RPS_IDX_PORT_B_DATA) begin
                latchB <= wb[2:0];
            end else if (index == `RPS_IDX_PORT_A_DIR) begin
                dirA <= wb;
            end else if (index == `RPS_IDX_PORT_B_DIR) begin
                dirB <= wb[2:0];
            end else if (index == `RPS_IDX_CTRL_A) begin
                // RULE7 RULE8 strobes not stored
                ctrlA <= wb[5:0];
            end else if (index == `RPS_IDX_CTRL_B) begin
                ctrlB <= wb;
            end else if (index == `RPS_IDX_DELAY) begin
                delayVal <= wb[6:0];
            end
        end
    end

    // RULE17 per-pin direction, each pin from its own flip-flops
    genvar pin;
    generate
        for (pin = 0; pin < PINS_A; pin = pin + 1) begin : g_pinA
            always @(posedge clk) begin
                if (reset) begin
                    portAOut[pin] <= LATCH_INIT[pin];
                    portAOe[pin]  <= DIR_INIT[pin];
                end else begin
                    portAOut[pin] <= latchA[pin];
                    portAOe[pin]  <= dirA[pin];
                end
            end
        end
        for (pin = 0; pin < PINS_B; pin = pin + 1) begin : g_pinB
            always @(posedge clk) begin
                if (reset) begin
                    portBOut[pin] <= LATCH_INIT[pin];
                    portBOe[pin]  <= DIR_INIT[pin];
                end else begin
                    portBOut[pin] <= latchB[pin];
                    portBOe[pin]  <= dirB[pin];
                end
            end
        end
    endgenerate

    // RULE20 two-stage input synchroniser
    always @(posedge clk) begin
        if (reset) begin
            syncA <= 3'h0;
            syncB <= 3'h0;
        end else begin
            syncA <= portBIn;
            syncB <= syncA;
        end
    end

    // Sampling run state; stop beats start when both arrive together
    always @(posedge clk) begin
        if (reset) begin
            sampling <= 1'b0;
        end else if (~nextEnable) begin
            // RULE1 idle while disabled
            sampling <= 1'b0;
        end else if (stopReq) begin
            sampling <= 1'b0;
        end else if (startReq) begin
            sampling <= 1'b1;
        end else if (positionDetected) begin
            sampling <= 1'b0;
        end
    end

    // RULE10 gating by sampling mode
    reg gateOk;
    always @* begin
        case (ctrlB[5:4])
            `RPS_SMODE_PWMON:  gateOk = pwmOn;
            `RPS_SMODE_ALWAYS: gateOk = 1'b1;
            `RPS_SMODE_LOWON:  gateOk = lowerPhaseOn;
            default:           gateOk = 1'b0;
        endcase
    end

    wire pwmRise = pwmOn & ~pwmOnPrev;
    // RULE15 delay counted in steps of eight clocks
    wire [9:0] delayTarget = {3'h0, delayVal} * `RPS_DELAY_STEP;
    // RULE11 divider taps 4, 8, 16, 32
    wire [5:0] divLen = `RPS_DIV_BASE << ctrlB[7:6];
    wire [4:0] divEnd = divLen[4:0] - 5'h01;
    wire sampleTick = sampling & gateOk & delayDone & (divCount == divEnd);

    always @(posedge clk) begin
        if (reset) begin
            divCount   <= 5'h00;
            delayCount <= 10'h000;
            delayDone  <= 1'b0;
            pwmOnPrev  <= 1'b0;
        end else begin
            pwmOnPrev <= pwmOn;
            if (~sampling | pwmRise) begin
                delayCount <= 10'h000;
                delayDone  <= (delayTarget == 10'h000);
            end else if (~delayDone) begin
                delayCount <= delayCount + 10'h001;
                delayDone  <= (delayCount + 10'h001 >= delayTarget);
            end
            if (~sampling | ~delayDone | (divCount == divEnd)) begin
                divCount <= 5'h00;
            end else begin
                divCount <= divCount + 5'h01;
            end
        end
    end

    // RULE4 three pins or first only; RULE2 unmatch inverts the test
    wire [2:0] cmpMask = ctrlA[`RPS_CA_ONEPIN] ? 3'h1 : 3'h7;
    wire equal = ((syncB ^ expectedPattern) & cmpMask) == 3'h0;
    wire hit = ctrlA[`RPS_CA_UNMATCH] ? ~equal : equal;
    wire [3:0] need = (ctrlB[3:0] == 4'h0) ? 4'h1 : ctrlB[3:0];

    always @(posedge clk) begin
        if (reset) begin
            matchCount       <= 4'h0;
            positionDetected <= 1'b0;
            heldLevels       <= 3'h0;
            location         <= `RPS_LOC_CURRENT;
            matchedInPulse   <= 1'b0;
            pulseSeen        <= 1'b0;
        end else begin
            positionDetected <= 1'b0;
            if (pwmRise) begin
                pulseSeen      <= 1'b1;
                matchedInPulse <= 1'b0;
            end
            if (~sampling) begin
                matchCount <= 4'h0;
            end else if (pwmRise & ctrlA[`RPS_CA_RECOUNT]) begin
                // RULE3 restart count each on-interval
                matchCount <= 4'h0;
            end else if (sampleTick) begin
                if (~hit) begin
                    // RULE19 mismatch clears counter
                    matchCount <= 4'h0;
                end else if (matchCount + 4'h1 >= need) begin
                    // RULE9 RULE19 required count reached
                    matchCount       <= 4'h0;
                    positionDetected <= 1'b1;
                    // RULE14 detection location
                    if (~pwmOn) begin
                        location <= `RPS_LOC_PWMOFF;
                    end else if (matchedInPulse | ~pulseSeen) begin
                        location <= `RPS_LOC_CURRENT;
                    end else begin
                        location <= `RPS_LOC_PRECEDING;
                    end
                    if (ctrlA[`RPS_CA_UNMATCH]) begin
                        // RULE12 hold sampled levels
                        heldLevels <= syncB;
                    end
                end else begin
                    matchCount     <= matchCount + 4'h1;
                    matchedInPulse <= pwmOn;
                end
            end
        end
    end
endmodule

/* sim/rps_pos_sensor.sv */
// Behavioural rotor position sensors feeding the port B inputs
`timescale 1ns/1ps
module rps_pos_sensor (
    // Clock and commanded pattern
    input  wire       clk,
    input  wire [2:0] pattern,
    input  wire [3:0] lag,
    // Sensor levels W V U
    output reg  [2:0] levels
);
    reg [2:0] pipe [0:15];
    integer   i;
    initial levels = 3'h0;
    always @(posedge clk) begin
        pipe[0] <= pattern;
        for (i = 1; i < 16; i = i + 1) pipe[i] <= pipe[i-1];
        // Lag lets the bench emulate slow comparators
        levels <= pipe[lag];
    end
endmodule

/* sim/rps_rotor_position_sampler_tb.sv */
// Self-checking bench for the rotor position sampler
`timescale 1ns/1ps
`include "rps_consts.vh"
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin fail_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, s); end end
module rps_rotor_position_sampler_tb;
    reg         clk, reset, psel, penable, pwrite, pwmOn, lowerPhaseOn, timer2Event, timer3Event;
    reg  [15:0] paddr;
    reg  [31:0] pwdata, r;
    reg  [7:0]  portAIn;
    reg  [2:0]  expectedPattern, pat;
    reg  [3:0]  lag;
    reg         err;
    wire [31:0] prdata;
    wire        pready, pslverr, positionDetected;
    wire [7:0]  portAOut, portAOe;
    wire [2:0]  portBIn, portBOut, portBOe;
    integer     fail_count = 0, tests_run = 0, n, k;
    reg  [15:0] lfsr = 16'd22162;
    int         mdl [int];
    rps_rotor_position_sampler u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe),
        .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe), .pwmOn(pwmOn),
        .lowerPhaseOn(lowerPhaseOn), .timer2Event(timer2Event), .timer3Event(timer3Event),
        .expectedPattern(expectedPattern), .positionDetected(positionDetected));
    rps_pos_sensor u_sens (.clk(clk), .pattern(pat), .lag(lag), .levels(portBIn));
    initial begin clk = 0; forever #4 clk = ~clk; end
    function [15:0] nxt(input [15:0] v);
        nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Request held until pready is sampled high
    task apb(input bit w, input [15:0] idx, input [7:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= {idx[13:0], 2'b00}; pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin fail_count++; end_of_test(); end
        r = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (w) mdl[idx] = d;
    endtask
    task rd(input string nm, input [15:0] idx, input [31:0] m);
        apb(0, idx, 8'h0);
        `CHK(nm, mdl[idx] & m, r & m)
    endtask
    task busy(input bit e);
        apb(0, `RPS_IDX_STATUS, 8'h0);
        `CHK("busy", e, r[3])
    endtask
    // Bounded wait for a detection pulse; running out ends the run
    task wait_det(input string nm);
        n = 0;
        while (positionDetected !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
        `CHK(nm, 1'b1, positionDetected)
        if (positionDetected !== 1'b1) end_of_test();
    endtask
    initial begin
        {psel, penable, pwrite, pwmOn, lowerPhaseOn, timer2Event, timer3Event} = 7'h0;
        reset = 1; paddr = 0; pwdata = 0; portAIn = 8'h00;
        expectedPattern = 0; pat = 0; lag = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        `CHK("latchA", 8'hff, portAOut)
        `CHK("oeA", 8'h00, portAOe)
        apb(1, `RPS_IDX_PORT_A_DIR, 8'h3c);
        rd("dirA", `RPS_IDX_PORT_A_DIR, 32'hff);
        portAIn <= ~lfsr[7:0];
        apb(1, `RPS_IDX_PORT_A_DATA, lfsr[7:0]);
        rd("dataA", `RPS_IDX_PORT_A_DATA, 32'h3c);
        `CHK("pinA", portAIn & 8'hc3, r[7:0] & 8'hc3)
        apb(1, `RPS_IDX_PORT_B_DIR, 8'h05);
        apb(1, `RPS_IDX_PORT_B_DATA, 8'h02);
        // Latch lands at the access edge, the pin flop one edge later
        repeat (2) @(posedge clk);
        `CHK("outB", 3'h2, portBOut)
        `CHK("oeB", 3'h5, portBOe)
        rd("dirB", `RPS_IDX_PORT_B_DIR, 32'h07);
        apb(1, `RPS_IDX_PORT_B_DIR, 8'h00);
        apb(1, `RPS_IDX_PORT_B_DATA, 8'h07);
        apb(0, 16'h0100, 8'h0);
        `CHK("unmapped", 1'b1, err)
        // Matching pattern, then a slower clock and one pin
        for (k = 0; k < 2; k++) begin
            lfsr = nxt(lfsr);
            pat <= lfsr[2:0]; expectedPattern <= lfsr[2:0]; lag <= 4'(k * 5);
            apb(1, `RPS_IDX_CTRL_A, 8'h00);
            apb(1, `RPS_IDX_DELAY, 8'h01);
            apb(1, `RPS_IDX_CTRL_B, {2'(k), 2'b01, 4'h3});
            apb(1, `RPS_IDX_CTRL_A, 8'(1 + k * 8));
            wait_det("detect");
            // Eight-clock delay, then three samples one divided period apart
            `CHK("spacing", 8 + 3 * (4 << k) + 1, n)
            apb(0, `RPS_IDX_STATUS, 8'h0);
            `CHK("idle", 1'b0, r[3])
            `CHK("where", 2'b01, r[5:4])
        end
        // Gated modes wait for their gate; PWM stays off so no samples
        apb(1, `RPS_IDX_CTRL_B, 8'h01);
        apb(1, `RPS_IDX_CTRL_A, 8'h00);
        apb(1, `RPS_IDX_CTRL_A, 8'h01);
        repeat (40) @(posedge clk);
        busy(1);
        apb(1, `RPS_IDX_CTRL_B, 8'h21);
        lowerPhaseOn <= 1'b1;
        wait_det("lowgate");
        lowerPhaseOn <= 1'b0;
        apb(1, `RPS_IDX_CTRL_B, 8'h13);
        // Mismatch keeps sampling running; exercise start and stop sources
        expectedPattern <= ~pat;
        apb(1, `RPS_IDX_CTRL_A, 8'h00);
        apb(1, `RPS_IDX_CTRL_A, 8'h31);
        busy(1);
        @(posedge clk) timer3Event <= 1'b1;
        @(posedge clk) timer3Event <= 1'b0;
        busy(0);
        @(posedge clk) timer2Event <= 1'b1;
        @(posedge clk) timer2Event <= 1'b0;
        busy(1);
        apb(1, `RPS_IDX_CTRL_A, 8'hb1);
        busy(0);
        apb(1, `RPS_IDX_CTRL_A, 8'h71);
        busy(1);
        apb(1, `RPS_IDX_CTRL_A, 8'h31);
        busy(1);
        apb(1, `RPS_IDX_CTRL_A, 8'h00);
        busy(0);
        // Unmatch mode counts differing samples and holds the levels
        apb(1, `RPS_IDX_CTRL_A, 8'h03);
        wait_det("unmatch");
        apb(0, `RPS_IDX_STATUS, 8'h0);
        `CHK("held", pat, r[2:0])
        end_of_test();
    end
endmodule

/* sim/rps_sampler_props.sv */
// Port-level checks on the rotor position sampler
`timescale 1ns/1ps
module rps_sampler_props #(
    parameter ABITS = 16
) (
    // Clock, reset and bus
    input wire             clk, reset, psel, penable, pwrite, pready, pslverr,
    input wire [ABITS-1:0] paddr,
    input wire [31:0]      pwdata, prdata,
    // Pins and result
    input wire [7:0]       portAOut, portAOe,
    input wire [2:0]       portBOe,
    input wire             positionDetected
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_ready_wait; psel && !penable |=> !pready ##1 pready; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("late pready");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
    property p_rd_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper data set");
    property p_dir_a; psel && penable && pready && pwrite && paddr == 16'h7e24 |-> ##2
        portAOe == $past(pwdata[7:0], 2);
    endproperty
    a_dir_a: assert property (p_dir_a) else $error("port A direction");
    property p_dir_b; psel && penable && pready && pwrite && paddr == 16'h7e28 |-> ##2
        portBOe == $past(pwdata[2:0], 2);
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("port B direction");
    property p_latch_a; psel && penable && pready && pwrite && paddr == 16'h000c |-> ##2
        portAOut == $past(pwdata[7:0], 2);
    endproperty
    a_latch_a: assert property (p_latch_a) else $error("port A latch");
    property p_det_pulse; positionDetected |=> !positionDetected; endproperty
    a_det_pulse: assert property (p_det_pulse) else $error("detect not a pulse");
endmodule
bind rps_rotor_position_sampler rps_sampler_props #(.ABITS(ABITS)) u_props (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .portAOut(portAOut),
    .portAOe(portAOe), .portBOe(portBOe), .positionDetected(positionDetected));
